// ### core/embmt_edge_det.sv
// Synchroniser and edge selector for the external edge input
`timescale 1ns/10ps
module embmt_edge_det (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Pin and edge choice
  input  wire logic       pin_i,
  input  wire logic [1:0] sel_i,
  // Results
  output logic            level_o,
  output logic            edge_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic rise;
  logic fall;

  // Oscillator stop freezes this path too
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign rise    = s2_reg & ~s3_reg;
  assign fall    = ~s2_reg & s3_reg;
  assign level_o = s2_reg;

  always_comb begin
    if (sel_i == embmt_pkg::ES_POS) begin
      edge_o = rise;
    end else if (sel_i == embmt_pkg::ES_NEG) begin
      edge_o = fall;
    end else if (sel_i == embmt_pkg::ES_ANY) begin
      edge_o = rise | fall;
    end else begin
      edge_o = 1'b0;
    end
  end
endmodule

// ### core/embmt_pkg.sv
// Shared constants for the eight-bit modem timer
// ==========================================================
package embmt_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [5:0] ADR_MODE = 6'h00;
  localparam logic [5:0] ADR_CTL  = 6'h04;
  localparam logic [5:0] ADR_STS  = 6'h08;
  localparam logic [5:0] ADR_CSEL = 6'h0C;
  localparam logic [5:0] ADR_CMA  = 6'h10;
  localparam logic [5:0] ADR_CMB  = 6'h14;
  localparam logic [5:0] ADR_CVA  = 6'h18;
  localparam logic [5:0] ADR_CVB  = 6'h1C;
  localparam logic [5:0] ADR_CAP  = 6'h20;
  localparam logic [5:0] ADR_SHF  = 6'h24;
  // ==========================================================
  // Reset values and field positions
  localparam logic [3:0] MODE_RST = 4'hF;
  localparam logic [3:0] CSEL_RST = 4'hF;
  localparam int CTL_RUN = 0;
  localparam int CTL_TS  = 1;
  localparam int CTL_TOP = 2;
  localparam int CTL_EIM = 3;
  localparam int CM_IRQ  = 0;
  localparam int CM_RST  = 1;
  localparam int CM_TOG  = 2;
  localparam int CM_SGL  = 3;
  localparam int STS_C1  = 0;
  localparam int STS_C2  = 1;
  localparam int STS_ED  = 2;
  // ==========================================================
  // Modes, clock sources, edge selects
  localparam logic [3:0] MD_PLAIN  = 4'hF;
  localparam logic [3:0] MD_XTRIG  = 4'hE;
  localparam logic [3:0] MD_ITRIG  = 4'hD;
  localparam logic [3:0] MD_REDIR1 = 4'hC;
  localparam logic [3:0] MD_REDIR2 = 4'hB;
  localparam logic [3:0] MD_BURSTN = 4'hA;
  localparam logic [3:0] MD_BURSTS = 4'h9;
  localparam logic [3:0] MD_FSK    = 4'h8;
  localparam logic [3:0] MD_PWM    = 4'h7;
  localparam logic [3:0] MD_MANCH  = 4'h6;
  localparam logic [3:0] MD_BIPH   = 4'h5;
  localparam logic [3:0] MD_XCAP   = 4'h4;
  localparam logic [1:0] CS_EDGE = 2'h0;
  localparam logic [1:0] CS_T1   = 2'h1;
  localparam logic [1:0] CS_NB   = 2'h2;
  localparam logic [1:0] CS_SYS  = 2'h3;
  localparam logic [1:0] ES_ANY  = 2'h0;
  localparam logic [1:0] ES_NEG  = 2'h1;
  localparam logic [1:0] ES_POS  = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_ARM  = 2'b01,
    ST_RUN  = 2'b11,
    ST_SYNC = 2'b10
  } embmt_state_t;
endpackage

// ### core/embmt_timer.sv
// Eight-bit modem timer with AXI4-Lite register access
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module embmt_timer (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // AXI4-Lite write
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer inputs
  input  wire logic        ext_edge_input_i,
  input  wire logic        neighbour_toggle_i,
  input  wire logic        neighbour_out_i,
  input  wire logic        neighbour_ff_i,
  input  wire logic        timer1_out_i,
  input  wire logic        serial_data_i,
  // Timer outputs
  output logic             timer_output_pin_o,
  output logic             own_toggle_o,
  output logic             timer_irq_o,
  output logic             shift_clk_o,
  output logic             shift_data_o
);
  // ==========================================================
  // Registers
  logic [3:0] mode_reg;
  logic [3:0] ctl_reg;
  logic [3:0] csel_reg;
  logic [3:0] cma_reg;
  logic [3:0] cmb_reg;
  logic [7:0] cva_reg;
  logic [7:0] cvb_reg;
  logic [2:0] sts_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cap_reg;
  logic [7:0] shf_reg;
  logic       tog_reg;
  logic       sel_b_reg;
  logic       done_a_reg;
  logic       done_b_reg;
  logic       bi_reg;
  logic       nbo_reg;
  logic       t1_reg;
  logic       aw_full_reg;
  logic       w_full_reg;
  logic [5:0] aw_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  embmt_pkg::embmt_state_t st_reg;
  embmt_pkg::embmt_state_t st_next;

  // ==========================================================
  // Decoded controls
  logic       ext_edge;
  logic       ext_lvl;
  logic       run;
  logic       tick;
  logic       counting;
  logic       use_b;
  logic       sup;
  logic       match;
  logic       hit_a;
  logic       hit_b;
  logic [7:0] cmp_val;
  logic [3:0] cm;
  logic       trig;
  logic       start;
  logic       restart;
  logic       demod;
  logic       bit_in;
  logic       wr_go;
  logic       rd_go;
  logic       wr_ctl;
  logic       sts_rd;

  embmt_edge_det u_edge (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (ext_edge_input_i),
    .sel_i     (csel_reg[3:2]),
    .level_o   (ext_lvl),
    .edge_o    (ext_edge)
  );

  // Disallowed modes keep the counter stopped
  assign run = ctl_reg[embmt_pkg::CTL_RUN] & (|mode_reg[3:2]);
  assign demod = (mode_reg == embmt_pkg::MD_MANCH) | (mode_reg == embmt_pkg::MD_BIPH);
  assign counting = (st_reg == embmt_pkg::ST_RUN) | (st_reg == embmt_pkg::ST_SYNC);
  assign start = (st_reg == embmt_pkg::ST_STOP) & run;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nbo_reg <= 1'b0;
      t1_reg  <= 1'b0;
    end else begin
      nbo_reg <= neighbour_out_i;
      t1_reg  <= timer1_out_i;
    end
  end

  always_comb begin
    case (csel_reg[1:0])
      embmt_pkg::CS_SYS: tick = 1'b1;
      embmt_pkg::CS_NB:  tick = neighbour_out_i & ~nbo_reg;
      embmt_pkg::CS_T1:  tick = timer1_out_i & ~t1_reg;
      default:           tick = ext_edge;
    endcase
  end

  // Trigger sources for the restart modes
  always_comb begin
    case (mode_reg)
      embmt_pkg::MD_XTRIG,
      embmt_pkg::MD_REDIR2: trig = ext_edge;
      embmt_pkg::MD_ITRIG,
      embmt_pkg::MD_PWM:    trig = neighbour_toggle_i;
      default:              trig = 1'b0;
    endcase
  end

  assign restart = ((st_reg == embmt_pkg::ST_RUN) & trig)
                 | ((st_reg == embmt_pkg::ST_SYNC) & ext_edge);

  // ==========================================================
  // Compare selection
  always_comb begin
    if ((mode_reg == embmt_pkg::MD_FSK) | (mode_reg == embmt_pkg::MD_PWM)) begin
      use_b = serial_data_i;
    end else if (cma_reg[embmt_pkg::CM_SGL] & done_a_reg) begin
      use_b = 1'b1;
    end else if (cmb_reg[embmt_pkg::CM_SGL] & done_b_reg) begin
      use_b = 1'b0;
    end else begin
      use_b = sel_b_reg;
    end
  end

  assign cmp_val = use_b ? cvb_reg : cva_reg;
  assign cm      = use_b ? cmb_reg : cma_reg;
  assign sup     = use_b ? (cmb_reg[embmt_pkg::CM_SGL] & done_b_reg)
                         : (cma_reg[embmt_pkg::CM_SGL] & done_a_reg);
  // Match on count x then clear gives period x+1
  assign match = counting & tick & ~restart & (cnt_reg == cmp_val) & ~sup;
  assign hit_a = match & ~use_b;
  assign hit_b = match & use_b;

  // ==========================================================
  // Run state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      embmt_pkg::ST_STOP: begin
        if (run) begin
          if ((mode_reg == embmt_pkg::MD_XTRIG) | (mode_reg == embmt_pkg::MD_REDIR2)) begin
            st_next = embmt_pkg::ST_ARM;
          end else begin
            st_next = embmt_pkg::ST_RUN;
          end
        end
      end
      embmt_pkg::ST_ARM: begin
        if (ext_edge) begin
          st_next = embmt_pkg::ST_RUN;
        end
      end
      embmt_pkg::ST_RUN: begin
        if (demod & hit_a) begin
          st_next = embmt_pkg::ST_SYNC;
        end
      end
      default: begin
        if (ext_edge) begin
          st_next = embmt_pkg::ST_RUN;
        end
      end
    endcase
    if (!run) begin
      st_next = embmt_pkg::ST_STOP;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg <= embmt_pkg::ST_STOP;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Counter and capture
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
    end else if (!counting || restart) begin
      cnt_reg <= 8'h00;
    end else if (match && cm[embmt_pkg::CM_RST]) begin
      cnt_reg <= 8'h00;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cap_reg <= 8'h00;
    end else begin
      case (mode_reg)
        embmt_pkg::MD_XTRIG,
        embmt_pkg::MD_REDIR2,
        embmt_pkg::MD_ITRIG: begin
          if (restart) begin
            cap_reg <= cnt_reg;
          end
        end
        embmt_pkg::MD_XCAP: begin
          if (ext_edge) begin
            cap_reg <= cnt_reg;
          end
        end
        default: cap_reg <= cnt_reg;
      endcase
    end
  end

  // Alternation and single-action bookkeeping
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sel_b_reg  <= 1'b0;
      done_a_reg <= 1'b0;
      done_b_reg <= 1'b0;
    end else if (start || restart || !counting) begin
      sel_b_reg  <= 1'b0;
      done_a_reg <= 1'b0;
      done_b_reg <= 1'b0;
    end else if (match) begin
      sel_b_reg  <= ~use_b;
      if (hit_a && cma_reg[embmt_pkg::CM_SGL]) begin
        done_a_reg <= 1'b1;
      end
      if (hit_b && cmb_reg[embmt_pkg::CM_SGL]) begin
        done_b_reg <= 1'b1;
      end
    end
  end

  // Preset only while stopped; toggle-with-start on the run edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tog_reg <= 1'b0;
    end else if (wr_ctl && !ctl_reg[embmt_pkg::CTL_RUN]) begin
      tog_reg <= wd_reg[embmt_pkg::CTL_TOP];
    end else if (start && ctl_reg[embmt_pkg::CTL_TS]) begin
      tog_reg <= ~tog_reg;
    end else if (match && cm[embmt_pkg::CM_TOG]) begin
      tog_reg <= ~tog_reg;
    end
  end

  // ==========================================================
  // Output stage
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      timer_output_pin_o <= 1'b0;
      own_toggle_o       <= 1'b0;
      timer_irq_o        <= 1'b0;
    end else begin
      own_toggle_o <= match & cm[embmt_pkg::CM_TOG];
      timer_irq_o  <= (match & cm[embmt_pkg::CM_IRQ])
                    | (ext_edge & ctl_reg[embmt_pkg::CTL_EIM] & ~run);
      case (mode_reg)
        embmt_pkg::MD_REDIR1,
        embmt_pkg::MD_REDIR2,
        embmt_pkg::MD_MANCH,
        embmt_pkg::MD_BIPH:   timer_output_pin_o <= neighbour_out_i;
        embmt_pkg::MD_BURSTN: timer_output_pin_o <= tog_reg & neighbour_ff_i;
        embmt_pkg::MD_BURSTS: timer_output_pin_o <= tog_reg & serial_data_i;
        default:              timer_output_pin_o <= tog_reg;
      endcase
    end
  end

  // ==========================================================
  // Demodulator
  assign bit_in = (mode_reg == embmt_pkg::MD_BIPH) ? bi_reg : ext_lvl;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bi_reg <= 1'b0;
    end else if (st_reg != embmt_pkg::ST_RUN) begin
      bi_reg <= 1'b0;
    end else if (hit_a) begin
      bi_reg <= 1'b0;
    end else if (ext_edge) begin
      bi_reg <= ~bi_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      shf_reg      <= 8'h00;
      shift_clk_o  <= 1'b0;
      shift_data_o <= 1'b0;
    end else begin
      shift_clk_o <= demod & hit_a;
      if (demod && hit_a) begin
        shf_reg      <= {shf_reg[6:0], bit_in};
        shift_data_o <= bit_in;
      end
    end
  end

  // ==========================================================
  // Status flags: a new event beats the read clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sts_reg <= 3'h0;
    end else begin
      sts_reg[embmt_pkg::STS_C1] <= hit_a | (sts_reg[embmt_pkg::STS_C1] & ~sts_rd);
      sts_reg[embmt_pkg::STS_C2] <= hit_b | (sts_reg[embmt_pkg::STS_C2] & ~sts_rd);
      sts_reg[embmt_pkg::STS_ED] <= ext_edge | (sts_reg[embmt_pkg::STS_ED] & ~sts_rd);
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go  = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign rd_go  = s_axi_arvalid & s_axi_arready;
  assign wr_ctl = wr_go & (aw_reg == embmt_pkg::ADR_CTL) & ws_reg[0];
  assign sts_rd = rd_go & (s_axi_araddr == embmt_pkg::ADR_STS);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_reg      <= 6'h00;
      wd_reg      <= 32'h0000_0000;
      ws_reg      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_reg      <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wd_reg     <= s_axi_wdata;
        ws_reg     <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_reg <= embmt_pkg::MODE_RST;
      ctl_reg  <= 4'h0;
      csel_reg <= embmt_pkg::CSEL_RST;
      cma_reg  <= 4'h0;
      cmb_reg  <= 4'h0;
      cva_reg  <= 8'h00;
      cvb_reg  <= 8'h00;
    end else if (wr_go && ws_reg[0]) begin
      if (aw_reg == embmt_pkg::ADR_MODE) begin
        mode_reg <= wd_reg[3:0];
      end else if (aw_reg == embmt_pkg::ADR_CTL) begin
        ctl_reg <= wd_reg[3:0];
      end else if (aw_reg == embmt_pkg::ADR_CSEL) begin
        csel_reg <= wd_reg[3:0];
      end else if (aw_reg == embmt_pkg::ADR_CMA) begin
        cma_reg <= wd_reg[3:0];
      end else if (aw_reg == embmt_pkg::ADR_CMB) begin
        cmb_reg <= wd_reg[3:0];
      end else if (aw_reg == embmt_pkg::ADR_CVA) begin
        cva_reg <= wd_reg[7:0];
      end else if (aw_reg == embmt_pkg::ADR_CVB) begin
        cvb_reg <= wd_reg[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= embmt_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if ((aw_reg <= embmt_pkg::ADR_CVB) && (aw_reg != embmt_pkg::ADR_STS)
          && (aw_reg[1:0] == 2'h0)) begin
        s_axi_bresp <= embmt_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= embmt_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= embmt_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= embmt_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      if (s_axi_araddr == embmt_pkg::ADR_MODE) begin
        s_axi_rdata[3:0] <= mode_reg;
      end else if (s_axi_araddr == embmt_pkg::ADR_CTL) begin
        s_axi_rdata[3:0] <= ctl_reg;
      end else if (s_axi_araddr == embmt_pkg::ADR_STS) begin
        s_axi_rdata[3:0] <= {counting, sts_reg};
      end else if (s_axi_araddr == embmt_pkg::ADR_CSEL) begin
        s_axi_rdata[3:0] <= csel_reg;
      end else if (s_axi_araddr == embmt_pkg::ADR_CMA) begin
        s_axi_rdata[3:0] <= cma_reg;
      end else if (s_axi_araddr == embmt_pkg::ADR_CMB) begin
        s_axi_rdata[3:0] <= cmb_reg;
      end else if (s_axi_araddr == embmt_pkg::ADR_CVA) begin
        s_axi_rdata[7:0] <= cva_reg;
      end else if (s_axi_araddr == embmt_pkg::ADR_CVB) begin
        s_axi_rdata[7:0] <= cvb_reg;
      end else if (s_axi_araddr == embmt_pkg::ADR_CAP) begin
        s_axi_rdata[7:0] <= cap_reg;
      end else if (s_axi_araddr == embmt_pkg::ADR_SHF) begin
        s_axi_rdata[7:0] <= shf_reg;
      end else begin
        s_axi_rresp <= embmt_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### testbench/eight_bit_modem_timer_bench.sv
// Self-checking bench for the modem timer
`timescale 1ns/10ps
module eight_bit_modem_timer_bench;
  // ==========================================================
  // Signals and instances
  logic        sys_clk_i, rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, ext_edge_input_i, part_run, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, neighbour_toggle_i, neighbour_out_i;
  logic        neighbour_ff_i, timer1_out_i, serial_data_i, timer_output_pin_o, own_toggle_o;
  logic        timer_irq_o, shift_clk_o, shift_data_o;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          miscompares = 0, cmp_count = 0, cyc = 0, irqs = 0, togs = 0;
  embmt_timer DUT (.*);
  embmt_partner_model PART (.sys_clk_i, .rst_i, .run_i(part_run),
    .neighbour_toggle_o(neighbour_toggle_i), .neighbour_out_o(neighbour_out_i),
    .neighbour_ff_o(neighbour_ff_i), .timer1_out_o(timer1_out_i), .serial_data_o(serial_data_i));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", n, exp, got);
    end
  endtask
  // One transfer; both valids held until their own ready
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    @(posedge sys_clk_i);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_bready  <= w;
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1 || s_axi_rvalid === 1'h1) begin
        rd_val = s_axi_rdata;
        chk("response", w ? s_axi_bresp : s_axi_rresp, er);
        break;
      end
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    acc(1'h1, a, d, embmt_pkg::RESP_OKAY);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    acc(1'h0, a, 32'h0, embmt_pkg::RESP_OKAY);
    chk("readback", rd_val, e);
  endtask
  task automatic wirq(output int t);
    t = 0;
    for (int i = 0; i < 300 && t == 0; i++) begin
      @(posedge sys_clk_i);
      if (timer_irq_o === 1'h1) t = cyc;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rchk(embmt_pkg::ADR_MODE, 32'hF);
    rchk(embmt_pkg::ADR_CSEL, 32'hF);
    acc(1'h1, embmt_pkg::ADR_STS, 32'h7, embmt_pkg::RESP_SLVERR);
    acc(1'h0, 6'h28, 32'h0, embmt_pkg::RESP_SLVERR);
    wreg(embmt_pkg::ADR_MODE, 32'h3);
    wreg(embmt_pkg::ADR_CTL, 32'h1);
    repeat (20) @(posedge sys_clk_i);
    rchk(embmt_pkg::ADR_CAP, 32'h0);
    wreg(embmt_pkg::ADR_CTL, 32'h0);
    wreg(embmt_pkg::ADR_MODE, 32'hF);
  endtask
  task automatic t_alt;
    int a, b, c;
    wreg(embmt_pkg::ADR_CVA, 32'h4);
    wreg(embmt_pkg::ADR_CVB, 32'h9);
    wreg(embmt_pkg::ADR_CMA, 32'h3);
    wreg(embmt_pkg::ADR_CMB, 32'h3);
    wreg(embmt_pkg::ADR_CTL, 32'h1);
    wirq(a);
    wirq(b);
    wirq(c);
    chk("second period", b - a, 32'hA);
    chk("third period", c - b, 32'h5);
    wreg(embmt_pkg::ADR_CTL, 32'h0);
    rchk(embmt_pkg::ADR_STS, 32'h3);
    rchk(embmt_pkg::ADR_STS, 32'h0);
  endtask
  task automatic t_single;
    int n, m;
    wreg(embmt_pkg::ADR_CMA, 32'hF);
    wreg(embmt_pkg::ADR_CVA, 32'h3);
    wreg(embmt_pkg::ADR_CMB, 32'h2);
    wreg(embmt_pkg::ADR_CVB, 32'h5);
    for (int k = 0; k < 2; k++) begin
      n = irqs;
      m = togs;
      wreg(embmt_pkg::ADR_CTL, 32'h1);
      repeat (60) @(posedge sys_clk_i);
      chk("single irqs", irqs - n, 32'h1);
      chk("single toggles", togs - m, 32'h1);
      wreg(embmt_pkg::ADR_CTL, 32'h0);
    end
  endtask
  task automatic t_capture;
    logic [31:0] c1;
    wreg(embmt_pkg::ADR_CMA, 32'h0);
    wreg(embmt_pkg::ADR_CMB, 32'h0);
    wreg(embmt_pkg::ADR_CTL, 32'h1);
    rchk(embmt_pkg::ADR_STS, 32'hB);
    acc(1'h0, embmt_pkg::ADR_CAP, 32'h0, embmt_pkg::RESP_OKAY);
    c1 = rd_val;
    acc(1'h0, embmt_pkg::ADR_CAP, 32'h0, embmt_pkg::RESP_OKAY);
    chk("capture moves", rd_val !== c1, 32'h1);
    wreg(embmt_pkg::ADR_CTL, 32'h0);
  endtask
  task automatic t_edge;
    logic [1:0] sel [3] = '{embmt_pkg::ES_POS, embmt_pkg::ES_NEG, embmt_pkg::ES_ANY};
    int n;
    wreg(embmt_pkg::ADR_CTL, 32'h8);
    for (int k = 0; k < 3; k++) begin
      wreg(embmt_pkg::ADR_CSEL, {sel[k], embmt_pkg::CS_SYS});
      n = irqs;
      ext_edge_input_i <= 1'h1;
      repeat (8) @(posedge sys_clk_i);
      chk("rise irq", irqs - n, sel[k] != embmt_pkg::ES_NEG);
      n = irqs;
      ext_edge_input_i <= 1'h0;
      repeat (8) @(posedge sys_clk_i);
      chk("fall irq", irqs - n, sel[k] != embmt_pkg::ES_POS);
    end
    rchk(embmt_pkg::ADR_STS, 32'h7);
    wreg(embmt_pkg::ADR_CTL, 32'h9);
    n = irqs;
    ext_edge_input_i <= 1'h1;
    repeat (8) @(posedge sys_clk_i);
    ext_edge_input_i <= 1'h0;
    repeat (8) @(posedge sys_clk_i);
    chk("irq while running", irqs - n, 32'h0);
    wreg(embmt_pkg::ADR_CTL, 32'h0);
  endtask
  task automatic t_redirect;
    logic v;
    wreg(embmt_pkg::ADR_MODE, embmt_pkg::MD_REDIR1);
    wreg(embmt_pkg::ADR_CTL, 32'h1);
    part_run <= 1'h1;
    for (int k = 0; k < 2; k++) begin
      v = neighbour_out_i;
      for (int i = 0; i < 20 && neighbour_out_i === v; i++) @(posedge sys_clk_i);
      repeat (3) @(posedge sys_clk_i);
      chk("output pin", timer_output_pin_o, neighbour_out_i);
    end
    part_run <= 1'h0;
    wreg(embmt_pkg::ADR_CTL, 32'h0);
  endtask
  // ==========================================================
  // Clock, watchdog and main sequence
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'h0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (timer_irq_o === 1'h1) irqs <= irqs + 1;
    if (own_toggle_o === 1'h1) togs <= togs + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    {rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h10;
    {s_axi_rready, ext_edge_input_i, part_run} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    t_regs;
    t_alt;
    t_single;
    t_capture;
    t_edge;
    t_redirect;
    report_and_stop;
  end
endmodule

// ### testbench/embmt_partner_model.sv
// Behavioural neighbour timer and serial data source
`timescale 1ns/10ps
module embmt_partner_model (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Frame enable from the bench
  input  wire logic run_i,
  // Toward the timer
  output logic      neighbour_toggle_o,
  output logic      neighbour_out_o,
  output logic      neighbour_ff_o,
  output logic      timer1_out_o,
  output logic      serial_data_o
);
  logic [2:0] div_reg;
  logic [7:0] tx_reg;
  // Frozen outside a frame, as a stopped neighbour would be
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_reg            <= 3'h0;
      neighbour_toggle_o <= 1'h0;
      neighbour_out_o    <= 1'h0;
      tx_reg             <= 8'hA5;
    end else begin
      neighbour_toggle_o <= run_i && div_reg == 3'h7;
      if (run_i) begin
        div_reg <= div_reg + 3'h1;
        if (div_reg == 3'h7) begin
          neighbour_out_o <= !neighbour_out_o;
          tx_reg          <= {tx_reg[6:0], tx_reg[7]};
        end
      end
    end
  end
  assign neighbour_ff_o = neighbour_out_o;
  assign timer1_out_o   = div_reg[1];
  assign serial_data_o  = tx_reg[7];
endmodule

// ### testbench/embmt_timer_monitor.sv
// Checker of bus handshakes and output timing of the modem timer
`timescale 1ns/10ps
module embmt_timer_monitor (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Timer outputs
  input wire logic        own_toggle_o,
  input wire logic        timer_irq_o,
  input wire logic        shift_clk_o
);
  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data wider than eight bits");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h24
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  reset_quiet_a: assert property ($past(rst_i) |-> !timer_irq_o && !own_toggle_o)
    else $error("timer event right after reset");
  irq_seen_c: cover property (timer_irq_o);
  toggle_seen_c: cover property (own_toggle_o);
  shift_seen_c: cover property (shift_clk_o);
endmodule

bind embmt_timer embmt_timer_monitor u_mon (.*);
